//--- core/gpxs_pkg.sv
// Purpose: shared constants for the bus-attached 16-bit port expander
// Assumes: registers live behind the two-wire serial link only
// Notes: register indices are command byte values
package gpxs_pkg;
    localparam int PORT_W = 16;
    localparam logic [7:0] CMD_INPUT0 = 8'h00;
    localparam logic [7:0] CMD_INPUT1 = 8'h01;
    localparam logic [7:0] CMD_OUT0 = 8'h02;
    localparam logic [7:0] CMD_OUT1 = 8'h03;
    localparam logic [7:0] CMD_POL0 = 8'h04;
    localparam logic [7:0] CMD_POL1 = 8'h05;
    localparam logic [7:0] CMD_CFG0 = 8'h06;
    localparam logic [7:0] CMD_CFG1 = 8'h07;
    localparam logic [7:0] CMD_DRV0 = 8'h40;
    localparam logic [7:0] CMD_DRV1 = 8'h41;
    localparam logic [7:0] CMD_DRV2 = 8'h42;
    localparam logic [7:0] CMD_DRV3 = 8'h43;
    localparam logic [7:0] CMD_LATCH0 = 8'h44;
    localparam logic [7:0] CMD_LATCH1 = 8'h45;
    localparam logic [7:0] CMD_MASK0 = 8'h4a;
    localparam logic [7:0] CMD_MASK1 = 8'h4b;
    localparam logic [7:0] CMD_STAT0 = 8'h4c;
    localparam logic [7:0] CMD_STAT1 = 8'h4d;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] DRV_FULL = 2'h3;
    localparam logic [1:0] DRV_HALF = 2'h2;
    localparam logic [3:0] ADDR_FIXED = 4'h4;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WRITE = 3'b011,
        ST_WRITE_ACK = 3'b100,
        ST_READ = 3'b101,
        ST_READ_ACK = 3'b110
    } gpxs_state_t;
endpackage

//--- core/gpxs_sync.sv
// Purpose: two-stage synchroniser for asynchronous levels
// Assumes: destination is clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module gpxs_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            dout <= '0;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

//--- core/gpxs_expander.sv
// Purpose: serial-bus slave, register pairs and change interrupt of a 16-bit expander
// Assumes: resetn is the internal power-on reset; scl and sda are sampled by clk
// Notes: pin drive strength is shown as a finger-enable mask per pin
// Operation
// - hold everything in reset until power good, then load defaults
// - only the power-on reset input resets the block
// - an input edge away from the value seen at the last port read raises the interrupt; latched pins on any edge
// - interrupt clears when a non-latched pin returns or its port is read
// - read clear happens at acknowledge bit after clock rises
// - after clearing, later input changes raise the interrupt again
// - output pins never interrupt; output-to-input may interrupt on mismatch
// - interrupt is open-drain active low, pulled up outside
// - latched pins clear only by reading their port or by being configured as outputs
// - each further write byte goes to the other pair register
// - any number of write bytes, alternating within the pair
// - successive read bytes alternate between pair registers
// - after repeated start, pointer follows the register last read
// - input data captured on falling edge of acknowledge clock
// - stop anywhere; data of latest acknowledge stays valid
// - four drive levels per pin; code 10b enables one finger
// - command 00 selects the input port register
// - masked changes stay silent; unmasking a pending change asserts
// - status bits show unmasked interrupt sources only
`timescale 1ns/1ps
module gpxs_expander (
    // clock and power-on reset
    input wire logic clk,
    input wire logic resetn,
    // address straps
    input wire logic [2:0] addrPin,
    // serial bus
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // interrupt, open drain
    output logic intOut,
    output logic intOe,
    // port pins
    input wire logic [gpxs_pkg::PORT_W-1:0] pinIn,
    output logic [gpxs_pkg::PORT_W-1:0] pinOut,
    output logic [gpxs_pkg::PORT_W-1:0] pinOe,
    output logic [2*gpxs_pkg::PORT_W-1:0] pinFingers
);
    localparam int N = gpxs_pkg::PORT_W;
    initial
    begin
        if (N != 16)
            $error("port width must be 16");
    end

    logic scl;
    logic sda;
    logic [N-1:0] pin;
    gpxs_sync #(.W(2)) uBus (
        .clk(clk),
        .resetn(resetn),
        .din({sclIn, sdaIn}),
        .dout({scl, sda})
    );
    gpxs_sync #(.W(N)) uPin (
        .clk(clk),
        .resetn(resetn),
        .din(pinIn),
        .dout(pin)
    );
    logic [2:0] addrSync;
    gpxs_sync #(.W(3)) uAddr (
        .clk(clk),
        .resetn(resetn),
        .din(addrPin),
        .dout(addrSync)
    );

    logic sclD_r;
    logic sdaD_r;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sclD_r <= 1'b1;
            sdaD_r <= 1'b1;
        end
        else
        begin
            sclD_r <= scl;
            sdaD_r <= sda;
        end
    end
    wire sclRise = scl && !sclD_r;
    wire sclFall = !scl && sclD_r;
    wire startCond = scl && sclD_r && !sda && sdaD_r;
    wire stopCond = scl && sclD_r && sda && !sdaD_r;

    // registers, reset to defaults by power-on reset only
    logic [N-1:0] outReg_r;
    logic [N-1:0] polReg_r;
    logic [N-1:0] cfgReg_r;
    logic [2*N-1:0] drvReg_r;
    logic [N-1:0] latchReg_r;
    logic [N-1:0] maskReg_r;
    logic [N-1:0] inReg_r;
    logic [N-1:0] pend_r;
    logic [N-1:0] refReg_r;
    logic [N-1:0] inNext;

    gpxs_pkg::gpxs_state_t state_r;
    logic [2:0] bitCnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic firstByte_r;
    logic isRead_r;
    logic ackDrive_r;
    logic [7:0] txByte_r;

    wire [7:0] pairPtr = {ptr_r[7:1], ~ptr_r[0]};
    wire [7:0] rxByte = {shift_r[6:0], sda};
    wire addrMatch = (rxByte[7:1] == {gpxs_pkg::ADDR_FIXED, addrSync});

    // read-data mux; cmd 00 is input port 0
    wire [N-1:0] inView = (pin ^ polReg_r) & cfgReg_r;
    wire [N-1:0] statView = pend_r & ~maskReg_r;
    logic [7:0] rdData;
    always_comb
    begin
        unique case (ptr_r)
            gpxs_pkg::CMD_INPUT0: rdData = inNext[7:0];
            gpxs_pkg::CMD_INPUT1: rdData = inNext[15:8];
            gpxs_pkg::CMD_OUT0: rdData = outReg_r[7:0];
            gpxs_pkg::CMD_OUT1: rdData = outReg_r[15:8];
            gpxs_pkg::CMD_POL0: rdData = polReg_r[7:0];
            gpxs_pkg::CMD_POL1: rdData = polReg_r[15:8];
            gpxs_pkg::CMD_CFG0: rdData = cfgReg_r[7:0];
            gpxs_pkg::CMD_CFG1: rdData = cfgReg_r[15:8];
            gpxs_pkg::CMD_DRV0: rdData = drvReg_r[7:0];
            gpxs_pkg::CMD_DRV1: rdData = drvReg_r[15:8];
            gpxs_pkg::CMD_DRV2: rdData = drvReg_r[23:16];
            gpxs_pkg::CMD_DRV3: rdData = drvReg_r[31:24];
            gpxs_pkg::CMD_LATCH0: rdData = latchReg_r[7:0];
            gpxs_pkg::CMD_LATCH1: rdData = latchReg_r[15:8];
            gpxs_pkg::CMD_MASK0: rdData = maskReg_r[7:0];
            gpxs_pkg::CMD_MASK1: rdData = maskReg_r[15:8];
            gpxs_pkg::CMD_STAT0: rdData = statView[7:0];
            gpxs_pkg::CMD_STAT1: rdData = statView[15:8];
            default: rdData = gpxs_pkg::BYTE_ZERO;
        endcase
    end

    // bus events
    wire addrDone = (state_r == gpxs_pkg::ST_ADDR) && sclRise && bitCnt_r == gpxs_pkg::BIT_LAST;
    wire wrDone = (state_r == gpxs_pkg::ST_WRITE) && sclRise && bitCnt_r == gpxs_pkg::BIT_LAST;
    wire wrStore = wrDone && !firstByte_r;
    // read clear at acknowledge bit after clock rises
    wire rdAckRise = (state_r == gpxs_pkg::ST_READ_ACK) && sclRise;
    wire rdPort0 = rdAckRise && ptr_r == gpxs_pkg::CMD_INPUT0;
    wire rdPort1 = rdAckRise && ptr_r == gpxs_pkg::CMD_INPUT1;
    wire [N-1:0] portRead = {{8{rdPort1}}, {8{rdPort0}}};
    // input capture on falling edge of the acknowledge clock
    wire inPtr = (ptr_r[7:1] == gpxs_pkg::CMD_INPUT0[7:1]);
    wire ackFall = sclFall && inPtr && ((state_r == gpxs_pkg::ST_ADDR_ACK && isRead_r
        && ackDrive_r) || state_r == gpxs_pkg::ST_READ_ACK);

    // interrupt source logic: edges against the value seen at the last port read
    logic [N-1:0] inViewD_r;
    wire [N-1:0] changed = (inView ^ inViewD_r) & cfgReg_r;
    wire [N-1:0] differs = inView ^ refReg_r;
    wire [N-1:0] pendSet = changed & (differs | latchReg_r);
    // non-latched pins clear when they return; latched only by read or by becoming an output
    wire [N-1:0] pendKeep = pend_r & cfgReg_r & ~portRead & (latchReg_r | differs);
    wire [N-1:0] pend_nxt = pendSet | pendKeep;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            inViewD_r <= '0;
            refReg_r <= '0;
        end
        else
        begin
            inViewD_r <= inView;
            refReg_r <= (refReg_r & ~portRead) | (inReg_r & portRead);
        end
    end
    wire intAssert = |(pend_r & ~maskReg_r);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pend_r <= '0;
        else
            pend_r <= pend_nxt;
    end

    // input register: loads pins at the acknowledge clock fall; latched pins also load on a change while not pending
    wire [N-1:0] inLoad = ackFall ? '1 : (latchReg_r & ~pend_r & changed);
    assign inNext = (inReg_r & ~inLoad) | (inView & inLoad);
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            inReg_r <= '0;
        else
            inReg_r <= inNext;
    end

    // serial state machine
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= gpxs_pkg::ST_IDLE;
            bitCnt_r <= gpxs_pkg::BIT_FIRST;
            shift_r <= gpxs_pkg::BYTE_ZERO;
            ptr_r <= gpxs_pkg::CMD_INPUT0;
            firstByte_r <= 1'b0;
            isRead_r <= 1'b0;
            ackDrive_r <= 1'b0;
            txByte_r <= gpxs_pkg::BYTE_ZERO;
        end
        else if (startCond)
        begin
            state_r <= gpxs_pkg::ST_ADDR;
            bitCnt_r <= gpxs_pkg::BIT_FIRST;
            ackDrive_r <= 1'b0;
        end
        else if (stopCond)
        begin
            state_r <= gpxs_pkg::ST_IDLE;
            ackDrive_r <= 1'b0;
        end
        else
        begin
            if (sclRise)
            begin
                shift_r <= rxByte;
                bitCnt_r <= bitCnt_r + 3'h1;
            end
            unique case (state_r)
                gpxs_pkg::ST_IDLE:
                begin
                    ackDrive_r <= 1'b0;
                end
                gpxs_pkg::ST_ADDR:
                begin
                    if (addrDone)
                    begin
                        if (addrMatch)
                        begin
                            state_r <= gpxs_pkg::ST_ADDR_ACK;
                            isRead_r <= sda;
                        end
                        else
                            state_r <= gpxs_pkg::ST_IDLE;
                    end
                end
                gpxs_pkg::ST_ADDR_ACK:
                begin
                    if (sclFall && !ackDrive_r)
                        ackDrive_r <= 1'b1;
                    else if (sclFall)
                    begin
                        ackDrive_r <= 1'b0;
                        bitCnt_r <= gpxs_pkg::BIT_FIRST;
                        firstByte_r <= 1'b1;
                        txByte_r <= rdData;
                        state_r <= isRead_r ? gpxs_pkg::ST_READ : gpxs_pkg::ST_WRITE;
                    end
                end
                gpxs_pkg::ST_WRITE:
                begin
                    if (wrDone)
                    begin
                        state_r <= gpxs_pkg::ST_WRITE_ACK;
                        if (firstByte_r)
                            ptr_r <= rxByte;
                        else
                            ptr_r <= pairPtr;
                        firstByte_r <= 1'b0;
                    end
                end
                gpxs_pkg::ST_WRITE_ACK:
                begin
                    if (sclFall && !ackDrive_r)
                        ackDrive_r <= 1'b1;
                    else if (sclFall)
                    begin
                        ackDrive_r <= 1'b0;
                        bitCnt_r <= gpxs_pkg::BIT_FIRST;
                        state_r <= gpxs_pkg::ST_WRITE;
                    end
                end
                gpxs_pkg::ST_READ:
                begin
                    // hold the last data bit until the clock falls
                    if (sclFall && bitCnt_r == gpxs_pkg::BIT_FIRST && !firstByte_r)
                        state_r <= gpxs_pkg::ST_READ_ACK;
                    else if (sclFall)
                        txByte_r <= {txByte_r[6:0], 1'b0};
                end
                gpxs_pkg::ST_READ_ACK:
                begin
                    if (sclRise)
                    begin
                        ptr_r <= pairPtr;
                        bitCnt_r <= gpxs_pkg::BIT_FIRST;
                        state_r <= sda ? gpxs_pkg::ST_IDLE : gpxs_pkg::ST_READ_ACK;
                    end
                    else if (sclFall)
                    begin
                        txByte_r <= rdData;
                        state_r <= gpxs_pkg::ST_READ;
                    end
                end
                default:
                begin
                    state_r <= gpxs_pkg::ST_IDLE;
                end
            endcase
            if (state_r == gpxs_pkg::ST_READ && sclRise)
                firstByte_r <= 1'b0;
        end
    end

    // write into the pointed register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            outReg_r <= {N{1'b1}};
            polReg_r <= '0;
            cfgReg_r <= {N{1'b1}};
            drvReg_r <= {N{gpxs_pkg::DRV_FULL}};
            latchReg_r <= '0;
            maskReg_r <= {N{1'b1}};
        end
        else if (wrStore)
        begin
            unique case (ptr_r)
                gpxs_pkg::CMD_OUT0: outReg_r[7:0] <= rxByte;
                gpxs_pkg::CMD_OUT1: outReg_r[15:8] <= rxByte;
                gpxs_pkg::CMD_POL0: polReg_r[7:0] <= rxByte;
                gpxs_pkg::CMD_POL1: polReg_r[15:8] <= rxByte;
                gpxs_pkg::CMD_CFG0: cfgReg_r[7:0] <= rxByte;
                gpxs_pkg::CMD_CFG1: cfgReg_r[15:8] <= rxByte;
                gpxs_pkg::CMD_DRV0: drvReg_r[7:0] <= rxByte;
                gpxs_pkg::CMD_DRV1: drvReg_r[15:8] <= rxByte;
                gpxs_pkg::CMD_DRV2: drvReg_r[23:16] <= rxByte;
                gpxs_pkg::CMD_DRV3: drvReg_r[31:24] <= rxByte;
                gpxs_pkg::CMD_LATCH0: latchReg_r[7:0] <= rxByte;
                gpxs_pkg::CMD_LATCH1: latchReg_r[15:8] <= rxByte;
                gpxs_pkg::CMD_MASK0: maskReg_r[7:0] <= rxByte;
                gpxs_pkg::CMD_MASK1: maskReg_r[15:8] <= rxByte;
                default: ;
            endcase
        end
    end

    // finger enables: code 0 drives no finger, codes 1 and 2 one of two fingers, code 3 both
    logic [2*N-1:0] fingers;
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            unique case (drvReg_r[2*i +: 2])
                2'h0: fingers[2*i +: 2] = 2'h0;
                2'h1: fingers[2*i +: 2] = 2'h1;
                gpxs_pkg::DRV_HALF: fingers[2*i +: 2] = 2'h2;
                default: fingers[2*i +: 2] = 2'h3;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            intOut <= 1'b0;
            intOe <= 1'b0;
            pinOut <= '0;
            pinOe <= '0;
            pinFingers <= '0;
        end
        else
        begin
            sdaOut <= 1'b0;
            sdaOe <= ackDrive_r || (state_r == gpxs_pkg::ST_READ && !txByte_r[7]);
            intOut <= 1'b0;
            intOe <= intAssert;
            pinOut <= outReg_r;
            pinOe <= ~cfgReg_r;
            pinFingers <= fingers;
        end
    end

    chk_int_follows: assert property (@(posedge clk) disable iff (!resetn)
        intAssert |=> intOe)
        else $error("interrupt not driven");
    chk_mask_silent: assert property (@(posedge clk) disable iff (!resetn)
        (&maskReg_r) |=> !intOe)
        else $error("masked change drove interrupt");
    chk_out_noint: assert property (@(posedge clk) disable iff (!resetn)
        (changed & ~cfgReg_r) == '0)
        else $error("output pin raised change");
    chk_stat_masked: assert property (@(posedge clk) disable iff (!resetn)
        (statView & maskReg_r) == '0)
        else $error("masked status bit set");
    chk_read_clear: assert property (@(posedge clk) disable iff (!resetn)
        rdPort0 && !(|changed[7:0]) && !startCond && !stopCond |=> pend_r[7:0] == '0)
        else $error("read did not clear pending");
    chk_pair_alt: assert property (@(posedge clk) disable iff (!resetn)
        rdAckRise && !startCond && !stopCond |=> ptr_r[0] != $past(ptr_r[0]))
        else $error("pointer did not alternate");
    chk_addr_ignore: assert property (@(posedge clk) disable iff (!resetn)
        addrDone && !addrMatch && !startCond && !stopCond |=> state_r == gpxs_pkg::ST_IDLE)
        else $error("foreign address taken");
    chk_change_sets: assert property (@(posedge clk) disable iff (!resetn)
        (|pendSet) && !(|portRead) |=> (|pend_r))
        else $error("change not flagged");
endmodule

//--- tb/gpxs_master.sv
// Purpose: two-wire bus master model that also resolves the interrupt line
// Assumes: open-drain lines with pull-ups; the slave never stretches the clock
// Notes: one bit is 7 clk low and 6 clk high; calls made only from the bench
`timescale 1ns/1ps
module gpxs_master (
    // clock
    input wire logic clk,
    // slave pull-down enables
    input wire logic sdaOe,
    input wire logic intOe,
    // resolved lines
    output logic scl,
    output logic sda,
    output logic intLine
);
    logic sclHigh = 1'b1;
    logic sdaHigh = 1'b1;
    // a line is low only while some party pulls it
    assign scl = sclHigh;
    assign sda = sdaHigh & ~sdaOe;
    assign intLine = ~intOe;

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic bitOut(input logic b);
        tick(3);
        sdaHigh = b;
        tick(4);
        sclHigh = 1'b1;
        tick(6);
        sclHigh = 1'b0;
    endtask

    task automatic bitIn(output logic b);
        tick(3);
        sdaHigh = 1'b1;
        tick(4);
        sclHigh = 1'b1;
        tick(3);
        b = sda;
        tick(3);
        sclHigh = 1'b0;
    endtask

    // only entered from an idle bus or from rstart
    task automatic start();
        tick(6);
        sdaHigh = 1'b0;
        tick(6);
        sclHigh = 1'b0;
    endtask

    task automatic rstart();
        tick(3);
        sdaHigh = 1'b1;
        tick(4);
        sclHigh = 1'b1;
        start();
    endtask

    task automatic stop();
        tick(3);
        sdaHigh = 1'b0;
        tick(4);
        sclHigh = 1'b1;
        tick(6);
        sdaHigh = 1'b1;
        tick(6);
    endtask

    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bitOut(d[i]);
        bitIn(a);
        ack = ~a;
    endtask

    task automatic recvByte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bitIn(d[i]);
        bitOut(last);
    endtask

    // the low n bytes of data go out, highest first
    task automatic writeRegs(input logic [6:0] addr, input logic [7:0] cmd,
        input logic [23:0] data, input int n, output logic acked);
        logic a;
        start();
        sendByte({addr, 1'b0}, acked);
        if (acked)
        begin
            sendByte(cmd, a);
            for (int i = n - 1; i >= 0; i--)
                sendByte(data[8*i+:8], a);
        end
        stop();
    endtask

    task automatic readBurst(input logic [6:0] addr, input int n, inout logic [31:0] got);
        logic a;
        logic [7:0] b;
        sendByte({addr, 1'b1}, a);
        for (int i = 0; i < n; i++)
        begin
            recvByte(i == n - 1, b);
            got = {got[23:0], b};
        end
    endtask

    // n2 above zero adds a second burst after a repeated start
    task automatic readRegs(input logic [6:0] addr, input logic [7:0] cmd,
        input int n1, input int n2, output logic [31:0] got);
        logic a;
        got = '0;
        start();
        sendByte({addr, 1'b0}, a);
        sendByte(cmd, a);
        rstart();
        readBurst(addr, n1, got);
        if (n2 > 0)
        begin
            rstart();
            readBurst(addr, n2, got);
        end
        stop();
    endtask
endmodule

//--- tb/gpxs_expander_bench.sv
// Purpose: self-checking bench for the port expander slave
// Assumes: master model drives the bus; outside pin levels come from extPin
// Notes: output pins read back their own drive
`timescale 1ns/1ps
module gpxs_expander_bench;
    localparam int LIMIT = 60000;
    localparam logic [6:0] ADDR = {gpxs_pkg::ADDR_FIXED, 3'h5};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] addrPin = 3'h5;
    logic [15:0] extPin = 16'h1234;
    logic [15:0] pinIn, pinOut, pinOe;
    logic [31:0] pinFingers;
    logic scl, sda, intLine, sdaOut, sdaOe, intOut, intOe, ack;
    logic [31:0] got;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 clk = ~clk;
    assign pinIn = (pinOe & pinOut) | (~pinOe & extPin);

    gpxs_master u_m (.clk(clk), .sdaOe(sdaOe), .intOe(intOe), .scl(scl), .sda(sda),
        .intLine(intLine));
    gpxs_expander u_dut (.clk(clk), .resetn(resetn), .addrPin(addrPin), .sclIn(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .intOut(intOut), .intOe(intOe),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinFingers(pinFingers));

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
            miscompares++;
        end
    endtask

    task automatic intExp(input string what, input logic on);
        repeat (20) @(negedge clk);
        check(what, {31'h0, on}, {31'h0, ~intLine});
    endtask

    task automatic defaults();
        check("pinOe", 32'h0, {16'h0, pinOe});
        check("pinOut", 32'hffff, {16'h0, pinOut});
        check("fingers", 32'hffffffff, pinFingers);
        check("drive zero", 32'h0, {30'h0, sdaOut, intOut});
        intExp("int idle", 1'b0);
    endtask

    task automatic testReset();
        defaults();
        u_m.readRegs(ADDR, gpxs_pkg::CMD_INPUT0, 2, 0, got);
        check("input pair", 32'h3412, got);
        $display("reset test done");
    endtask

    task automatic testWrite();
        u_m.writeRegs(ADDR, gpxs_pkg::CMD_OUT1, 24'ha1b2c3, 3, ack);
        check("ack", 32'h1, {31'h0, ack});
        check("out pair", 32'hc3b2, {16'h0, pinOut});
        u_m.writeRegs(ADDR, gpxs_pkg::CMD_DRV0, 24'hfeff, 2, ack);
        check("fingers", 32'hfffffffe, pinFingers);
        u_m.writeRegs({gpxs_pkg::ADDR_FIXED, 3'h2}, gpxs_pkg::CMD_OUT0, 24'h0, 1, ack);
        check("foreign ack", 32'h0, {31'h0, ack});
        check("out kept", 32'hc3b2, {16'h0, pinOut});
        u_m.readRegs(ADDR, gpxs_pkg::CMD_OUT1, 1, 1, got);
        check("restart read", 32'hc3b2, got);
        $display("write test done");
    endtask

    task automatic testIntr();
        u_m.writeRegs(ADDR, gpxs_pkg::CMD_MASK0, 24'h0, 2, ack);
        u_m.readRegs(ADDR, gpxs_pkg::CMD_INPUT0, 2, 0, got);
        intExp("int clear", 1'b0);
        extPin[9] = 1'b0;
        intExp("int change", 1'b1);
        u_m.readRegs(ADDR, gpxs_pkg::CMD_STAT0, 2, 0, got);
        check("status", 32'h0002, got);
        intExp("int after status", 1'b1);
        u_m.readRegs(ADDR, gpxs_pkg::CMD_INPUT1, 1, 0, got);
        check("port1", 32'h10, got);
        intExp("int port read", 1'b0);
        extPin[9] = 1'b1;
        intExp("int again", 1'b1);
        extPin[9] = 1'b0;
        intExp("int returned", 1'b0);
        u_m.writeRegs(ADDR, gpxs_pkg::CMD_MASK1, 24'h02, 1, ack);
        extPin[9] = 1'b1;
        intExp("int masked", 1'b0);
        u_m.writeRegs(ADDR, gpxs_pkg::CMD_MASK1, 24'h00, 1, ack);
        intExp("int unmasked", 1'b1);
        u_m.readRegs(ADDR, gpxs_pkg::CMD_INPUT1, 1, 0, got);
        u_m.writeRegs(ADDR, gpxs_pkg::CMD_CFG0, 24'h00, 1, ack);
        intExp("int outputs", 1'b0);
        u_m.writeRegs(ADDR, gpxs_pkg::CMD_OUT0, 24'h5a, 1, ack);
        check("out0", 32'hc35a, {16'h0, pinOut});
        intExp("int output move", 1'b0);
        $display("interrupt test done");
    endtask

    task automatic testLatch();
        u_m.writeRegs(ADDR, gpxs_pkg::CMD_LATCH1, 24'h01, 1, ack);
        extPin[8] = 1'b1;
        repeat (20) @(negedge clk);
        extPin[8] = 1'b0;
        intExp("int latched", 1'b1);
        extPin[8] = 1'b1;
        u_m.readRegs(ADDR, gpxs_pkg::CMD_INPUT1, 1, 0, got);
        check("latched bit", 32'h1, {31'h0, got[0]});
        intExp("int latch read", 1'b0);
        $display("latch test done");
    endtask

    task automatic testReset2();
        resetn = 1'b0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        defaults();
        $display("second reset test done");
    endtask

    initial
    begin
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        testReset();
        testWrite();
        testIntr();
        testLatch();
        testReset2();
        stop_test();
    end
endmodule
